// *** rtl/ltw_ctrl.sv ***
`timescale 1ns/1ps
`include "ltw_defines.svh"

// Operation
// - A table write to program memory starts a long write and halts execution.
// - Only an interrupt source or reset ends the long write.
// - A source ends the write only with enable and flag both set.
// - Core source ending the write clears the highest-priority enabled core flag.
// - Pending interrupt at table write aborts it as a no-op, clearing the highest-priority live core flag, if any.
// - Peripheral ending the write with interrupts enabled vectors and keeps its flag.
// - Global disable clear before the write means vectoring when it ends.
// - Global disable set before the write means no vectoring when it ends.
// - Core source with interrupts disabled ends without vectoring, flag cleared.
// - Peripheral with interrupts disabled ends without vectoring, flag left set.
module ltw_ctrl #(
   parameter int NUM_PERIPH = `LTW_NUM_PERIPH_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic table_write_instruction_i,
   input wire logic global_interrupt_disable_i,
   input wire logic [`LTW_NUM_CORE-1:0] core_enable_i,
   input wire logic [`LTW_NUM_CORE-1:0] core_flag_i,
   input wire logic [NUM_PERIPH-1:0] periph_enable_i,
   input wire logic [NUM_PERIPH-1:0] periph_flag_i,
   output logic exec_halt_o,
   output logic write_active_o,
   output logic [`LTW_NUM_CORE-1:0] core_flag_clear_o,
   output ltw_pkg::ltw_end_s write_end_o
);

   ltw_pkg::ltw_state_e state_ff;
   logic gid_at_start_ff;
   logic nxt_gid_at_start;
   logic [`LTW_NUM_CORE-1:0] core_flag_clear_ff;
   logic [`LTW_NUM_CORE-1:0] nxt_core_flag_clear;
   logic end_valid_ff;
   logic nxt_end_valid;
   logic end_vector_ff;
   logic nxt_end_vector;
   logic end_aborted_ff;
   logic nxt_end_aborted;
   logic [`LTW_NUM_CORE-1:0] core_live;
   logic [`LTW_NUM_CORE-1:0] core_pick;
   logic [NUM_PERIPH-1:0] periph_live;
   logic core_any;
   logic periph_any;
   logic any_live;
   logic in_idle;
   logic in_write;
   logic start_write;
   logic abort_write;
   logic finish_write;
   logic end_event;

   // Lowest index wins, so the external pin outranks the timer sources.
   function automatic logic [`LTW_NUM_CORE-1:0] pick_first(input logic [`LTW_NUM_CORE-1:0] req);
      logic [`LTW_NUM_CORE-1:0] one_hot;
      logic found;
      one_hot = '0;
      found = 1'h0;
      for (int i = 0; i < `LTW_NUM_CORE; i++) begin
         if (req[i] && !found) begin
            one_hot[i] = 1'h1;
            found = 1'h1;
         end
      end
      return one_hot;
   endfunction

   // A set flag with a clear enable, or the reverse, must never end the write.
   function automatic logic source_live(input logic enable, input logic flag);
      return enable & flag;
   endfunction

   always_comb begin
      core_live = '0;
      for (int i = 0; i < `LTW_NUM_CORE; i++) begin
         core_live[i] = source_live(core_enable_i[i], core_flag_i[i]);
      end
   end

   always_comb begin
      periph_live = '0;
      for (int i = 0; i < NUM_PERIPH; i++) begin
         periph_live[i] = source_live(periph_enable_i[i], periph_flag_i[i]);
      end
   end

   assign core_any = |core_live;
   assign periph_any = |periph_live;
   assign any_live = core_any | periph_any;
   assign core_pick = pick_first(core_live);
   assign in_idle = (state_ff == ltw_pkg::LTW_IDLE);
   assign in_write = (state_ff == ltw_pkg::LTW_WRITING);

   // A source already pending at the table write turns it into a no-op rather than a write.
   assign start_write = in_idle && table_write_instruction_i && !any_live;
   assign abort_write = in_idle && table_write_instruction_i && any_live;
   assign finish_write = in_write && any_live;
   assign end_event = finish_write || abort_write;

   assign exec_halt_o = in_write;
   assign write_active_o = in_write;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= ltw_pkg::LTW_IDLE;
      end else begin
         case (state_ff)
            ltw_pkg::LTW_IDLE: begin
               if (start_write) begin
                  state_ff <= ltw_pkg::LTW_WRITING;
               end
            end
            ltw_pkg::LTW_WRITING: begin
               if (finish_write) begin
                  state_ff <= ltw_pkg::LTW_IDLE;
               end
            end
            default: begin
               state_ff <= ltw_pkg::LTW_IDLE;
            end
         endcase
      end
   end

   // The disable bit is sampled when the write begins; later changes do not alter vectoring.
   always_comb begin
      nxt_gid_at_start = gid_at_start_ff;
      if (start_write) begin
         nxt_gid_at_start = global_interrupt_disable_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gid_at_start_ff <= `LTW_GID_RESET;
      end else begin
         gid_at_start_ff <= nxt_gid_at_start;
      end
   end

   // The highest-priority live core flag is cleared whether or not the end vectors; peripheral flags are never touched.
   always_comb begin
      nxt_core_flag_clear = '0;
      if (end_event) begin
         nxt_core_flag_clear = core_pick;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_flag_clear_ff <= '0;
      end else begin
         core_flag_clear_ff <= nxt_core_flag_clear;
      end
   end

   always_comb begin
      nxt_end_valid = 1'h0;
      if (end_event) begin
         nxt_end_valid = 1'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         end_valid_ff <= 1'h0;
      end else begin
         end_valid_ff <= nxt_end_valid;
      end
   end

   // An abort never vectors here; the ordinary interrupt logic takes the pending source.
   always_comb begin
      nxt_end_vector = 1'h0;
      if (finish_write) begin
         nxt_end_vector = !gid_at_start_ff;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         end_vector_ff <= 1'h0;
      end else begin
         end_vector_ff <= nxt_end_vector;
      end
   end

   always_comb begin
      nxt_end_aborted = 1'h0;
      if (abort_write) begin
         nxt_end_aborted = 1'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         end_aborted_ff <= 1'h0;
      end else begin
         end_aborted_ff <= nxt_end_aborted;
      end
   end

   assign core_flag_clear_o = core_flag_clear_ff;
   assign write_end_o = '{valid: end_valid_ff, vector: end_vector_ff, aborted: end_aborted_ff};

endmodule

// *** rtl/ltw_defines.svh ***
`ifndef LTW_DEFINES_SVH
`define LTW_DEFINES_SVH

// Core source indices, highest priority first.
`define LTW_SRC_EXT_PIN 0
`define LTW_SRC_TIMER0_OVERFLOW_SOURCE_OVF 1
`define LTW_SRC_T0_CLKIN 2
`define LTW_NUM_CORE 3
`define LTW_NUM_PERIPH_DEF 8
// Until the first write begins, vectoring is treated as disabled.
`define LTW_GID_RESET 1'h1

`endif

// *** rtl/ltw_pkg.sv ***
package ltw_pkg;
   typedef enum {
      LTW_IDLE,
      LTW_WRITING
   } ltw_state_e;

   typedef struct packed {
      logic valid;
      logic vector;
      logic aborted;
   } ltw_end_s;
endpackage

// *** verif/long_table_write_control_tb_top.sv ***
`timescale 1ns/1ps
module long_table_write_control_tb_top;
   logic clk_i = 1'h0, rst_i = 1'h1, table_write_instruction_i = 1'h0, global_interrupt_disable_i = 1'h0;
   logic exec_halt_o, write_active_o;
   logic [2:0] core_enable_i = 3'h0, core_flag_i, core_flag_clear_o, fire = 3'h0;
   logic [7:0] periph_enable_i = 8'h0, periph_flag_i = 8'h0;
   ltw_pkg::ltw_end_s write_end_o;
   int miscompares = 0, checks_done = 0, cycles = 0;
   always #2 clk_i = ~clk_i;
   ltw_ctrl i_ltw_ctrl(.clk_i(clk_i), .rst_i(rst_i), .table_write_instruction_i(table_write_instruction_i),
      .global_interrupt_disable_i(global_interrupt_disable_i), .core_enable_i(core_enable_i),
      .core_flag_i(core_flag_i), .periph_enable_i(periph_enable_i), .periph_flag_i(periph_flag_i),
      .exec_halt_o(exec_halt_o), .write_active_o(write_active_o), .core_flag_clear_o(core_flag_clear_o),
      .write_end_o(write_end_o));
   ltw_fw_model i_ltw_fw_model(.clk_i, .rst_i, .fire_i(fire), .clr_i(core_flag_clear_o), .flag_o(core_flag_i));
   task chk(input logic [7:0] s, x);
      checks_done++;
      if (s !== x) $display("unexpected at %0t: %h, expected %h", $time, s, x);
      if (s !== x) miscompares++;
   endtask
   task test_done;
      $display("miscompares %0d checks_done %0d", miscompares, checks_done);
      if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(negedge clk_i) if (++cycles == 999) begin
      miscompares++;
      test_done;
   end
   task go;
      @(negedge clk_i) table_write_instruction_i = 1'h1;
      @(negedge clk_i) table_write_instruction_i = 1'h0;
   endtask
   // Source s below 3 is a core source, 3 a peripheral; a flag without its enable must not end the write.
   task t_end(input int s, input logic g);
      core_enable_i = 3'h1 << s;
      periph_enable_i = {7'h0, s > 2};
      global_interrupt_disable_i = g;
      go;
      periph_flag_i = 8'h02;
      repeat (4) @(negedge clk_i) chk({exec_halt_o, write_active_o}, 2'h3);
      fire = core_enable_i;
      @(negedge clk_i) fire = 3'h0;
      periph_flag_i = {7'h0, s > 2};
      @(negedge clk_i) chk(write_end_o, {1'h1, ~g, 1'h0});
      chk(core_flag_clear_o, core_enable_i);
      chk({exec_halt_o, write_active_o}, 2'h0);
      periph_flag_i = 8'h00;
   endtask
   // Reset is the only other way out of a long write, and it must leave no end pulse behind.
   task t_reset;
      core_enable_i = 3'h0;
      periph_enable_i = 8'h00;
      go;
      repeat (2) @(negedge clk_i) chk(exec_halt_o, 1'h1);
      rst_i = 1'h1;
      @(negedge clk_i) chk({exec_halt_o, write_active_o, write_end_o, core_flag_clear_o}, 8'h00);
      rst_i = 1'h0;
      repeat (2) @(negedge clk_i) chk({exec_halt_o, write_end_o}, 4'h0);
   endtask
   // Flags already pending at the table write turn it into a no-op, one core flag cleared each time.
   task t_abort;
      core_enable_i = 3'h7;
      fire = 3'h6;
      go;
      fire = 3'h0;
      chk({write_end_o, core_flag_clear_o}, 6'h2A);
      chk(exec_halt_o, 1'h0);
      go;
      chk({write_end_o, core_flag_clear_o}, 6'h2C);
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'h0;
      for (int i = 0; i < 8; i++) t_end(i % 4, i[2]);
      t_reset;
      t_abort;
      test_done;
   end
endmodule

// *** verif/ltw_chk.sv ***
`timescale 1ns/1ps
module ltw_chk #(parameter int NUM_PERIPH = 8) (
   input wire logic clk_i, rst_i, table_write_instruction_i, global_interrupt_disable_i, exec_halt_o,
   input wire logic [2:0] core_enable_i, core_flag_i, core_flag_clear_o,
   input wire logic [NUM_PERIPH-1:0] periph_enable_i, periph_flag_i,
   input wire ltw_pkg::ltw_end_s write_end_o);
   wire h = exec_halt_o;
   wire s = table_write_instruction_i && !h;
   wire [2:0] c = core_enable_i & core_flag_i;
   wire [2:0] lo = c & -c;
   wire [2:0] q = core_flag_clear_o;
   wire [2:0] e = write_end_o;
   wire p = |c || |(periph_enable_i & periph_flag_i);
   logic g_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i or posedge rst_i) g_ff <= rst_i ? 1'h0 : (s && !p) ? global_interrupt_disable_i : g_ff;
   a_start_halt: assert property (s && !p |=> h) else $error("no halt");
   a_halt_hold: assert property (h && !p |=> h && !e) else $error("early end");
   a_source_end: assert property (h && p |=> !h && e[2]) else $error("no end");
   a_abort_nop: assert property (s && p |=> !h && e == 3'h5) else $error("abort");
   a_vector_gid: assert property (h && p |=> e[1] != g_ff) else $error("vector");
   a_core_clear: assert property ((s || h) && c |=> q == $past(lo))
      else $error("clear");
   a_periph_keep: assert property (h && !c && p |=> !q) else $error("periph");
   a_idle_quiet: assert property (!s && !h |=> !e && !q) else $error("stray");
   c_abort: cover property (e[0]);
   c_vector: cover property (e[1]);
   c_quiet: cover property (e[2] && !e[1]);
endmodule
bind ltw_ctrl ltw_chk #(.NUM_PERIPH(NUM_PERIPH)) i_ltw_chk(.clk_i(clk_i), .rst_i(rst_i),
   .table_write_instruction_i(table_write_instruction_i),
   .global_interrupt_disable_i(global_interrupt_disable_i),
   .exec_halt_o(exec_halt_o), .core_enable_i(core_enable_i), .core_flag_i(core_flag_i),
   .core_flag_clear_o(core_flag_clear_o), .periph_enable_i(periph_enable_i), .periph_flag_i(periph_flag_i),
   .write_end_o(write_end_o));

// *** verif/ltw_fw_model.sv ***
`timescale 1ns/1ps
module ltw_fw_model (input wire logic clk_i, input wire logic rst_i, input wire logic [2:0] fire_i,
   input wire logic [2:0] clr_i, output logic [2:0] flag_o);
   // A flag holds until the clear pulse; a fire in the same cycle as its clear is lost.
   always_ff @(posedge clk_i or posedge rst_i) flag_o <= rst_i ? 3'h0 : (flag_o | fire_i) & ~clr_i;
endmodule
